// >>> src/tfp_parser.sv
// transmit request frame parser: checks, decodes, hands off, answers
`timescale 1ns/100ps
module tfp_parser
    import tfp_pkg::*;
#(
    parameter logic [15:0] MAX_PAYLOAD = MAX_PAYLOAD_DEF,
    parameter int PAY_DEPTH = 256,
    parameter logic [15:0] CFG_PROFILE = 16'h0000,
    parameter int AW = $clog2(PAY_DEPTH)
) (
    input wire logic REF_CLK, // 50 MHz clock
    input wire logic RST_N, // async reset, active low
    input wire logic [7:0] RX_DATA, // command byte from host
    input wire logic RX_VALID, // command byte strobe
    input wire logic [7:0] DEFAULT_HOP_LIMIT, // hop limit for radius zero
    input wire logic [7:0] DEFAULT_TRANSMIT_OPTIONS, // options for byte zero
    input wire logic [7:0] CONFIGURED_SOURCE_ENDPOINT, // source endpoint
    input wire logic [7:0] CONFIGURED_DESTINATION_ENDPOINT, // destination endpoint
    input wire logic [15:0] CONFIGURED_CLUSTER_ID, // cluster identifier
    output logic [15:0] MAX_PAYLOAD_QUERY, // reported maximum payload
    output logic TX_REQ, // descriptor valid, held until done
    output tfp_desc_t TX_DESC, // packet descriptor
    input wire logic [AW-1:0] PAY_RD_ADDR, // radio payload read address
    output logic [7:0] PAY_RD_DATA, // payload byte, one cycle late
    input wire logic RADIO_DONE, // radio finished the packet
    input wire logic [7:0] RADIO_RETRIES, // retry count
    input wire logic [7:0] RADIO_DELIVERY, // delivery status, zero is success
    input wire logic [7:0] RADIO_DISCOVERY, // discovery status
    output logic ROUTE_INFO_REQ, // pulse: emit route information frame
    output logic [7:0] STAT_DATA, // answer byte
    output logic STAT_VALID, // answer byte valid
    input wire logic STAT_READY, // host takes answer byte
    output logic FRAME_ERR, // pulse: frame discarded
    output logic FRAME_DROP // pulse: frame refused while busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LEN_HI = 3'b001,
        ST_LEN_LO = 3'b010,
        ST_BODY = 3'b011,
        ST_CKS = 3'b100,
        ST_RADIO = 3'b101,
        ST_ANSWER = 3'b110,
        ST_SKIP = 3'b111
    } tfp_state_t;

    tfp_state_t state;
    logic [15:0] len;
    logic [15:0] off;
    logic [7:0] sum;
    logic [7:0] ftype;
    logic [7:0] frame_id;
    logic [63:0] dest;
    logic [7:0] radius;
    logic [7:0] opts;
    logic [7:0] src_ep;
    logic [7:0] dst_ep;
    logic [15:0] cluster;
    logic [15:0] profile;
    logic explicit_f;
    logic [15:0] pay_start;
    logic [15:0] pay_len;
    logic [15:0] last_off;
    logic [7:0] eff_opts;
    logic bcast;
    logic [15:0] limit;
    logic frame_ok;
    logic ans_start;
    logic ans_idle;
    tfp_status_t ans;
    logic pay_wr;
    logic [AW-1:0] pay_waddr;

    // limit on payload for a given options byte
    function automatic logic [15:0] pay_limit(input logic [7:0] o);
        pay_limit = o[OPT_ENCRYPT] ? MAX_PAYLOAD - ENCRYPT_OVERHEAD : MAX_PAYLOAD;
    endfunction : pay_limit

    // zero selects the configured default
    function automatic logic [7:0] or_default(input logic [7:0] v, input logic [7:0] d);
        or_default = (v == 8'h00) ? d : v;
    endfunction : or_default

    assign explicit_f = (ftype == TYPE_EXPLICIT);
    assign pay_start = explicit_f ? XOFF_PAY : OFF_PAY;
    assign last_off = len + OFF_TYPE - 16'h0001;
    assign pay_len = len + OFF_TYPE - pay_start;
    assign eff_opts = or_default(opts, DEFAULT_TRANSMIT_OPTIONS);
    assign bcast = (dest == BCAST_ADDR);
    assign limit = pay_limit(eff_opts);
    assign pay_wr = (state == ST_BODY) && RX_VALID && (off >= pay_start)
        && (off - pay_start < 16'(PAY_DEPTH));
    assign pay_waddr = AW'(off - pay_start);

    // a frame is acted on only when every check passes
    always_comb begin
        frame_ok = 1'b1;
        if (ftype != TYPE_TX_REQ && ftype != TYPE_EXPLICIT) begin
            frame_ok = 1'b0;
        end else if (len + OFF_TYPE < pay_start) begin
            frame_ok = 1'b0;
        end else if (pay_len > limit) begin
            frame_ok = 1'b0;
        end else if (eff_opts[OPT_DELIV_LO+:2] == DELIV_INVALID) begin
            frame_ok = 1'b0;
        end else if (8'(sum + RX_DATA) != CKS_TARGET) begin
            frame_ok = 1'b0;
        end
    end

    // frame sequencing
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            len <= 16'h0000;
            off <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (RX_VALID && RX_DATA == START_DELIM) begin
                        state <= ST_LEN_HI;
                    end
                end
                ST_LEN_HI: begin
                    if (RX_VALID) begin
                        len[15:8] <= RX_DATA;
                        state <= ST_LEN_LO;
                    end
                end
                ST_LEN_LO: begin
                    if (RX_VALID) begin
                        len[7:0] <= RX_DATA;
                        off <= OFF_TYPE;
                        state <= ({len[15:8], RX_DATA} == 16'h0000) ? ST_CKS : ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (RX_VALID) begin
                        off <= off + 16'h0001;
                        if (off == last_off) begin
                            state <= ST_CKS;
                        end
                    end
                end
                ST_CKS: begin
                    if (RX_VALID) begin
                        state <= frame_ok ? ST_RADIO : ST_IDLE;
                    end
                end
                ST_RADIO: begin
                    if (RADIO_DONE) begin
                        state <= (frame_id == 8'h00) ? ST_IDLE : ST_ANSWER;
                    end
                end
                ST_ANSWER: begin
                    if (ans_idle && !ans_start) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // running checksum over type byte through last body byte
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sum <= 8'h00;
        end else if (state == ST_LEN_LO) begin
            sum <= 8'h00;
        end else if (state == ST_BODY && RX_VALID) begin
            sum <= sum + RX_DATA;
        end
    end

    // header field capture by documented offset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ftype <= 8'h00;
            frame_id <= 8'h00;
            dest <= 64'h0;
            radius <= 8'h00;
            opts <= 8'h00;
            src_ep <= 8'h00;
            dst_ep <= 8'h00;
            cluster <= 16'h0000;
            profile <= 16'h0000;
        end else if (state == ST_LEN_LO && RX_VALID) begin
            ftype <= 8'h00;
        end else if (state == ST_BODY && RX_VALID) begin
            if (off == OFF_TYPE) begin
                ftype <= RX_DATA;
            end else if (off == OFF_ID) begin
                frame_id <= RX_DATA;
            end else if (off >= OFF_DEST && off < OFF_RSV) begin
                dest <= {dest[55:0], RX_DATA};
            end else if (!explicit_f) begin
                // the reserved pair at 13 is skipped on purpose
                if (off == OFF_RADIUS) begin
                    radius <= RX_DATA;
                end else if (off == OFF_OPTS) begin
                    opts <= RX_DATA;
                end
            end else begin
                if (off == XOFF_SRC_EP) begin
                    src_ep <= RX_DATA;
                end else if (off == XOFF_DST_EP) begin
                    dst_ep <= RX_DATA;
                end else if (off == XOFF_CLUSTER || off == XOFF_CLUSTER + 16'h0001) begin
                    cluster <= {cluster[7:0], RX_DATA};
                end else if (off == XOFF_PROFILE || off == XOFF_PROFILE + 16'h0001) begin
                    profile <= {profile[7:0], RX_DATA};
                end else if (off == XOFF_RADIUS) begin
                    radius <= RX_DATA;
                end else if (off == XOFF_OPTS) begin
                    opts <= RX_DATA;
                end
            end
        end
    end

    // descriptor handed to the radio side
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_REQ <= 1'b0;
            TX_DESC <= '0;
        end else if (state == ST_CKS && RX_VALID && frame_ok) begin
            TX_REQ <= 1'b1;
            TX_DESC.frame_id <= frame_id;
            TX_DESC.dest <= dest;
            TX_DESC.broadcast <= bcast;
            // hop radius matters only for broadcasts
            TX_DESC.hops <= bcast ? or_default(radius, DEFAULT_HOP_LIMIT) : 8'h00;
            TX_DESC.delivery <= eff_opts[OPT_DELIV_LO+:2];
            TX_DESC.no_ack <= eff_opts[OPT_NO_ACK] && !bcast;
            TX_DESC.no_discovery <= eff_opts[OPT_NO_DISC] && !bcast
                && eff_opts[OPT_DELIV_LO+:2] == DELIV_MESH;
            TX_DESC.nack <= eff_opts[OPT_NACK];
            TX_DESC.trace <= eff_opts[OPT_TRACE];
            TX_DESC.encrypt <= eff_opts[OPT_ENCRYPT];
            if (explicit_f) begin
                TX_DESC.src_ep <= src_ep;
                TX_DESC.dst_ep <= dst_ep;
                TX_DESC.cluster <= cluster;
                TX_DESC.profile <= profile;
            end else begin
                TX_DESC.src_ep <= CONFIGURED_SOURCE_ENDPOINT;
                TX_DESC.dst_ep <= CONFIGURED_DESTINATION_ENDPOINT;
                TX_DESC.cluster <= CONFIGURED_CLUSTER_ID;
                TX_DESC.profile <= CFG_PROFILE;
            end
            TX_DESC.pay_len <= pay_len;
        end else if (state == ST_RADIO && RADIO_DONE) begin
            TX_REQ <= 1'b0;
        end
    end

    // route information request after the radio reports
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ROUTE_INFO_REQ <= 1'b0;
        end else begin
            ROUTE_INFO_REQ <= state == ST_RADIO && RADIO_DONE && !TX_DESC.broadcast
                && TX_DESC.delivery == DELIV_MESH
                && ((TX_DESC.nack && RADIO_DELIVERY != 8'h00)
                || TX_DESC.trace);
        end
    end

    // answer launch; identifier zero loads the answer fields but never raises start
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ans_start <= 1'b0;
            ans <= '0;
        end else begin
            ans_start <= state == ST_RADIO && RADIO_DONE && frame_id != 8'h00;
            if (state == ST_RADIO && RADIO_DONE) begin
                ans.frame_id <= frame_id;
                ans.retries <= RADIO_RETRIES;
                ans.delivery <= RADIO_DELIVERY;
                ans.discovery <= RADIO_DISCOVERY;
            end
        end
    end

    // error and refusal pulses
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            FRAME_ERR <= 1'b0;
            FRAME_DROP <= 1'b0;
        end else begin
            FRAME_ERR <= state == ST_CKS && RX_VALID && !frame_ok;
            // bytes arriving while a packet is in flight are not buffered
            FRAME_DROP <= (state == ST_RADIO || state == ST_ANSWER) && RX_VALID
                && RX_DATA == START_DELIM;
        end
    end

    // maximum payload under the default options
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            MAX_PAYLOAD_QUERY <= MAX_PAYLOAD;
        end else begin
            MAX_PAYLOAD_QUERY <= pay_limit(DEFAULT_TRANSMIT_OPTIONS);
        end
    end

    tfp_pay_mem #(
        .WIDTH(8),
        .DEPTH(PAY_DEPTH),
        .AW(AW)
    ) u_mem (
        .clk(REF_CLK),
        .wr_en(pay_wr),
        .wr_addr(pay_waddr),
        .wr_data(RX_DATA),
        .rd_addr(PAY_RD_ADDR),
        .rd_data(PAY_RD_DATA)
    );

    tfp_status_tx u_stat (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .start(ans_start),
        .stat(ans),
        .idle(ans_idle),
        .data(STAT_DATA),
        .valid(STAT_VALID),
        .ready(STAT_READY)
    );
endmodule : tfp_parser

// >>> src/tfp_pkg.sv
// constants and carrier types for the transmit request frame parser
package tfp_pkg;
    localparam logic [7:0] START_DELIM = 8'h7E;
    localparam logic [7:0] TYPE_TX_REQ = 8'h10;
    localparam logic [7:0] TYPE_EXPLICIT = 8'h11;
    localparam logic [7:0] TYPE_EXT_STATUS = 8'h8B;
    localparam logic [7:0] CKS_TARGET = 8'hFF;
    // documented byte offsets within a frame
    localparam logic [15:0] OFF_TYPE = 16'h0003;
    localparam logic [15:0] OFF_ID = 16'h0004;
    localparam logic [15:0] OFF_DEST = 16'h0005;
    localparam logic [15:0] OFF_RSV = 16'h000D;
    localparam logic [15:0] OFF_RADIUS = 16'h000F;
    localparam logic [15:0] OFF_OPTS = 16'h0010;
    localparam logic [15:0] OFF_PAY = 16'h0011;
    localparam logic [15:0] XOFF_SRC_EP = 16'h000F;
    localparam logic [15:0] XOFF_DST_EP = 16'h0010;
    localparam logic [15:0] XOFF_CLUSTER = 16'h0011;
    localparam logic [15:0] XOFF_PROFILE = 16'h0013;
    localparam logic [15:0] XOFF_RADIUS = 16'h0015;
    localparam logic [15:0] XOFF_OPTS = 16'h0016;
    localparam logic [15:0] XOFF_PAY = 16'h0017;
    localparam logic [63:0] BCAST_ADDR = 64'h0000_0000_0000_FFFF;
    // transmit option bit positions
    localparam int OPT_NO_ACK = 0;
    localparam int OPT_NO_DISC = 1;
    localparam int OPT_NACK = 2;
    localparam int OPT_TRACE = 3;
    localparam int OPT_ENCRYPT = 4;
    localparam int OPT_DELIV_LO = 6;
    localparam logic [15:0] ENCRYPT_OVERHEAD = 16'h0004;
    localparam logic [1:0] DELIV_INVALID = 2'h0;
    localparam logic [1:0] DELIV_MESH = 2'h3;
    // extended status answer layout
    localparam logic [15:0] STATUS_LEN = 16'h0007;
    localparam logic [15:0] STATUS_ADDR16 = 16'hFFFE;
    localparam logic [3:0] STATUS_BYTES = 4'hB;
    localparam logic [15:0] MAX_PAYLOAD_DEF = 16'h0100;

    typedef struct packed {
        logic [7:0] frame_id;
        logic [63:0] dest;
        logic broadcast;
        logic [7:0] hops;
        logic [1:0] delivery;
        logic no_ack;
        logic no_discovery;
        logic nack;
        logic trace;
        logic encrypt;
        logic [7:0] src_ep;
        logic [7:0] dst_ep;
        logic [15:0] cluster;
        logic [15:0] profile;
        logic [15:0] pay_len;
    } tfp_desc_t;

    typedef struct packed {
        logic [7:0] frame_id;
        logic [7:0] retries;
        logic [7:0] delivery;
        logic [7:0] discovery;
    } tfp_status_t;
endpackage : tfp_pkg

// >>> src/tfp_pay_mem.sv
// payload buffer with registered read data
`timescale 1ns/100ps
module tfp_pay_mem
    import tfp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk, // system clock
    input wire logic wr_en, // write strobe
    input wire logic [AW-1:0] wr_addr, // write address
    input wire logic [WIDTH-1:0] wr_data, // write data
    input wire logic [AW-1:0] rd_addr, // read address
    output logic [WIDTH-1:0] rd_data // read data, one cycle late
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : tfp_pay_mem

// >>> src/tfp_status_tx.sv
// serialiser for the extended transmit status answer frame
`timescale 1ns/100ps
module tfp_status_tx
    import tfp_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic start, // send one answer
    input wire tfp_status_t stat, // answer contents
    output logic idle, // ready for start
    output logic [7:0] data, // answer byte
    output logic valid, // answer byte valid
    input wire logic ready // host takes byte
);
    tfp_status_t held;
    logic [3:0] idx;
    logic [7:0] sum;
    logic [7:0] next_byte;

    always_comb begin
        case (idx)
            4'h0: next_byte = START_DELIM;
            4'h1: next_byte = STATUS_LEN[15:8];
            4'h2: next_byte = STATUS_LEN[7:0];
            4'h3: next_byte = TYPE_EXT_STATUS;
            4'h4: next_byte = held.frame_id;
            4'h5: next_byte = STATUS_ADDR16[15:8];
            4'h6: next_byte = STATUS_ADDR16[7:0];
            4'h7: next_byte = held.retries;
            4'h8: next_byte = held.delivery;
            4'h9: next_byte = held.discovery;
            default: next_byte = CKS_TARGET - sum;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held <= '0;
            idx <= 4'h0;
            sum <= 8'h00;
            idle <= 1'b1;
            valid <= 1'b0;
            data <= 8'h00;
        end else if (idle) begin
            if (start) begin
                held <= stat;
                idle <= 1'b0;
                idx <= 4'h0;
                sum <= 8'h00;
            end
        end else if (!valid || ready) begin
            if (idx == STATUS_BYTES) begin
                valid <= 1'b0;
                idle <= 1'b1;
            end else begin
                data <= next_byte;
                valid <= 1'b1;
                idx <= idx + 4'h1;
                if (idx >= 4'h3) begin
                    sum <= sum + next_byte;
                end
            end
        end
    end
endmodule : tfp_status_tx

// >>> verification/tfp_parser_sva.sv
// concurrent checks on the transmit request frame parser ports
`timescale 1ns/100ps
module tfp_parser_chk
    import tfp_pkg::*;
(
    input wire logic REF_CLK, // clock
    input wire logic RST_N, // reset, active low
    input wire logic TX_REQ, // descriptor valid
    input wire tfp_desc_t TX_DESC, // descriptor
    input wire logic RADIO_DONE, // radio finished
    input wire logic [7:0] RADIO_DELIVERY, // delivery status
    input wire logic ROUTE_INFO_REQ, // route info pulse
    input wire logic [7:0] STAT_DATA, // answer byte
    input wire logic STAT_VALID, // answer valid
    input wire logic STAT_READY, // answer taken
    input wire logic FRAME_ERR // discard pulse
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_done;
        TX_REQ && RADIO_DONE;
    endsequence
    sequence s_route_due;
        s_done ##0 (TX_DESC.delivery == DELIV_MESH && !TX_DESC.broadcast
            && (TX_DESC.trace || (TX_DESC.nack && RADIO_DELIVERY != 8'h00)));
    endsequence
    property p_stat_hold;
        STAT_VALID && !STAT_READY |=> STAT_VALID && $stable(STAT_DATA);
    endproperty
    a_stat_hold: assert property (p_stat_hold) else $error("answer byte changed unaccepted");
    property p_desc_stable;
        TX_REQ ##1 TX_REQ |-> $stable(TX_DESC);
    endproperty
    a_desc_stable: assert property (p_desc_stable) else $error("descriptor moved");
    property p_req_drop;
        s_done |=> !TX_REQ;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request held after done");
    property p_answer;
        s_done ##0 (TX_DESC.frame_id != 8'h00) |-> ##3 (STAT_VALID && STAT_DATA == START_DELIM);
    endproperty
    a_answer: assert property (p_answer) else $error("answer did not start");
    property p_silent;
        s_done ##0 (TX_DESC.frame_id == 8'h00) |=> !STAT_VALID [*4];
    endproperty
    a_silent: assert property (p_silent) else $error("answer sent for id zero");
    property p_route;
        s_route_due |=> ROUTE_INFO_REQ;
    endproperty
    a_route: assert property (p_route) else $error("route info missing");
    property p_route_cause;
        ROUTE_INFO_REQ |-> $past(TX_REQ) && $past(RADIO_DONE);
    endproperty
    a_route_cause: assert property (p_route_cause) else $error("route info uncaused");
    property p_err_pulse;
        FRAME_ERR |=> !FRAME_ERR;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("discard pulse too long");
    property p_bcast;
        TX_REQ |-> TX_DESC.broadcast == (TX_DESC.dest == BCAST_ADDR);
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");
    property p_uni_hops;
        TX_REQ && !TX_DESC.broadcast |-> TX_DESC.hops == 8'h00;
    endproperty
    a_uni_hops: assert property (p_uni_hops) else $error("unicast carries hops");
    property p_deliv;
        TX_REQ |-> TX_DESC.delivery != DELIV_INVALID;
    endproperty
    a_deliv: assert property (p_deliv) else $error("invalid delivery accepted");
endmodule : tfp_parser_chk

bind tfp_parser tfp_parser_chk chk_u (.*);

// >>> verification/tfp_host_model.sv
// host side model: takes status answer bytes, promptly or with stalls
`timescale 1ns/100ps
module tfp_host_model (
    input wire logic clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic slow, // stall three cycles in four
    input wire logic [7:0] data, // answer byte
    input wire logic valid, // answer byte valid
    output logic ready // byte taken
);
    logic [7:0] got[$];
    logic [1:0] gap;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
            gap <= 2'h0;
        end else begin
            gap <= gap + 2'h1;
            ready <= !slow || gap == 2'h3;
            // kept in order to match the echoed id
            if (valid && ready) got.push_back(data);
        end
    end
endmodule : tfp_host_model

// >>> verification/tb_top.sv
// self-checking bench for the transmit request frame parser
`timescale 1ns/100ps
module tb_top;
    import tfp_pkg::*;
    localparam logic [15:0] MAXP = 16'h0010;
    logic REF_CLK, RST_N, RX_VALID, RADIO_DONE, STAT_READY, FRAME_ERR, FRAME_DROP, slow;
    logic TX_REQ, ROUTE_INFO_REQ, STAT_VALID;
    logic [7:0] RX_DATA, DEFAULT_HOP_LIMIT, DEFAULT_TRANSMIT_OPTIONS, CONFIGURED_SOURCE_ENDPOINT;
    logic [7:0] CONFIGURED_DESTINATION_ENDPOINT, RADIO_RETRIES, RADIO_DELIVERY, RADIO_DISCOVERY;
    logic [7:0] PAY_RD_ADDR, PAY_RD_DATA, STAT_DATA, id, rad, opts, sep, dep;
    logic [15:0] CONFIGURED_CLUSTER_ID, MAX_PAYLOAD_QUERY, clu, prof;
    logic [63:0] dest;
    tfp_desc_t TX_DESC;
    int error_cnt = 0;
    int n_tests = 0;
    int plen;
    integer seed = 32'hf8f9148b;
    logic [7:0] ot[4] = '{8'hD4, 8'hD4, 8'h01, 8'hCC};
    int pt[4] = '{12, 13, 0, 16};

    tfp_parser #(.MAX_PAYLOAD(MAXP)) dut_u (.*);
    tfp_host_model host_u (.clk(REF_CLK), .rst_n(RST_N), .slow(slow), .data(STAT_DATA),
        .valid(STAT_VALID), .ready(STAT_READY));

    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [159:0] e, input logic [159:0] g);
        n_tests++;
        if (e !== g) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic tick(inout int k, input string nm);
        @(posedge REF_CLK);
        #1;
        k++;
        if (k > 400) begin
            error_cnt++;
            $display("[ERR] %s expected done seen timeout", nm);
            report_and_stop();
        end
    endtask : tick

    task automatic send(input logic [7:0] v);
        @(posedge REF_CLK);
        RX_VALID <= 1'b1;
        RX_DATA <= v;
    endtask : send

    task automatic run(input logic [7:0] typ, input logic bad);
        logic [7:0] b[$];
        logic [7:0] a[$];
        logic [7:0] s;
        logic [7:0] eo;
        logic ok;
        logic x, bc;
        tfp_desc_t d;
        int k;
        eo = (opts == 8'h00) ? DEFAULT_TRANSMIT_OPTIONS : opts;
        x = typ == TYPE_EXPLICIT;
        b = {typ, id};
        for (k = 7; k >= 0; k--) b.push_back(dest[8*k+:8]);
        b = {b, 8'hFF, 8'hFE};
        if (x) b = {b, sep, dep, clu[15:8], clu[7:0], prof[15:8], prof[7:0]};
        b = {b, rad, opts};
        for (k = 0; k < plen; k++) b.push_back(8'(k * 37) ^ id);
        s = 8'h00;
        foreach (b[j]) s += b[j];
        send(START_DELIM);
        send(8'(b.size() >> 8));
        send(8'(b.size()));
        foreach (b[j]) send(b[j]);
        send((CKS_TARGET - s) ^ {7'h00, bad});
        @(posedge REF_CLK);
        RX_VALID <= 1'b0;
        ok = !bad && (typ == TYPE_TX_REQ || x) && eo[7:6] != DELIV_INVALID
            && plen <= (eo[OPT_ENCRYPT] ? MAXP - ENCRYPT_OVERHEAD : MAXP);
        k = 0;
        #1;
        while (TX_REQ !== 1'b1 && FRAME_ERR !== 1'b1) tick(k, "frame outcome");
        chk("accepted", ok, TX_REQ);
        if (ok) begin
            bc = dest == BCAST_ADDR;
            d = '{id, dest, bc, bc ? (rad != 8'h00 ? rad : DEFAULT_HOP_LIMIT) : 8'h00, eo[7:6],
                !bc && eo[0], !bc && eo[7:6] == DELIV_MESH && eo[1], eo[2], eo[3], eo[4],
                x ? sep : CONFIGURED_SOURCE_ENDPOINT, x ? dep : CONFIGURED_DESTINATION_ENDPOINT,
                x ? clu : CONFIGURED_CLUSTER_ID, x ? prof : 16'h0000, 16'(plen)};
            chk("descriptor", d, TX_DESC);
            // a start byte while the packet is in flight must be refused
            send(START_DELIM);
            @(posedge REF_CLK);
            RX_VALID <= 1'b0;
            #1;
            chk("busy start dropped", 1'b1, FRAME_DROP);
            for (k = 0; k < plen; k++) begin
                @(posedge REF_CLK);
                PAY_RD_ADDR <= 8'(k);
                @(posedge REF_CLK);
                #1;
                chk("payload", 8'(k * 37) ^ id, PAY_RD_DATA);
            end
            @(posedge REF_CLK);
            RADIO_DONE <= 1'b1;
            RADIO_RETRIES <= 8'($random(seed));
            RADIO_DELIVERY <= seed[3] ? 8'h00 : 8'($random(seed));
            RADIO_DISCOVERY <= 8'($random(seed));
            @(posedge REF_CLK);
            RADIO_DONE <= 1'b0;
            a = {START_DELIM, 8'h00, 8'h07, TYPE_EXT_STATUS, id, 8'hFF, 8'hFE, RADIO_RETRIES};
            a = {a, RADIO_DELIVERY, RADIO_DISCOVERY};
            s = 8'h00;
            for (k = 3; k < 10; k++) s += a[k];
            a.push_back(CKS_TARGET - s);
            k = 0;
            while (id != 8'h00 && host_u.got.size() < 11) tick(k, "answer");
            if (id != 8'h00) foreach (a[j]) chk("answer byte", a[j], host_u.got[j]);
        end
        repeat (6) @(posedge REF_CLK);
        chk("answer count", (ok && id != 8'h00) ? 11 : 0, host_u.got.size());
        host_u.got.delete();
        $display("test type %0h id %0h accepted %0b done", typ, id, ok);
    endtask : run

    initial begin
        {RST_N, RX_VALID, RADIO_DONE, slow} = 4'h0;
        {RX_DATA, PAY_RD_ADDR, RADIO_RETRIES, RADIO_DELIVERY, RADIO_DISCOVERY} = 40'h0;
        {DEFAULT_HOP_LIMIT, CONFIGURED_SOURCE_ENDPOINT, CONFIGURED_DESTINATION_ENDPOINT} = 24'h0;
        DEFAULT_TRANSMIT_OPTIONS = 8'hC0;
        CONFIGURED_CLUSTER_ID = 16'h0000;
        repeat (5) @(posedge REF_CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 44; i++) begin
            @(posedge REF_CLK);
            // delivery nonzero keeps zero options valid
            DEFAULT_TRANSMIT_OPTIONS <= (8'($random(seed)) & 8'h5F) | 8'h40;
            DEFAULT_HOP_LIMIT <= 8'($random(seed));
            CONFIGURED_SOURCE_ENDPOINT <= 8'($random(seed));
            CONFIGURED_DESTINATION_ENDPOINT <= 8'($random(seed));
            CONFIGURED_CLUSTER_ID <= 16'($random(seed));
            slow <= i[0];
            id = (i % 4 == 0) ? 8'h00 : 8'($random(seed));
            dest = (i % 3 == 0) ? BCAST_ADDR : {$random(seed), $random(seed)};
            rad = (i % 2 == 0) ? 8'h00 : 8'($random(seed));
            opts = (i % 5 == 0) ? 8'h00 : 8'($random(seed)) & 8'hDF;
            {sep, dep, clu, prof} = 48'({$random(seed), $random(seed)});
            plen = {$random(seed)} % 17;
            if (i >= 40) begin
                id = 8'hA5;
                dest = 64'h0000_0000_0000_0001;
                opts = ot[i-40];
                plen = pt[i-40];
            end
            repeat (2) @(posedge REF_CLK);
            #1;
            chk("max payload", DEFAULT_TRANSMIT_OPTIONS[4] ? MAXP - 16'h0004 : MAXP,
                MAX_PAYLOAD_QUERY);
            run((i % 7 == 6) ? 8'h12 : (i[1] ? TYPE_EXPLICIT : TYPE_TX_REQ), i % 9 == 8);
        end
        report_and_stop();
    end
endmodule : tb_top
